// ---- hdl/frs_fault_retry_sequencer.sv ----
// frs_fault_retry_sequencer: automatic retry after protective trips of a motor drive.
// assumes trip inputs are one-cycle events on mclk from the fault detectors,
// and that run control performs the restart and soft fault reset it is told to.
//
// Contract
// R01: retry only fault classes enabled by selection
// R02: count limit zero disables retry
// R03: limit 1..10: retries, alarm inactive
// R04: limit 101..110: limit minus 100, alarm on
// R05: too many failures: excess fault, trip
// R06: wait 0..360 s, reset 1 s, zero=0.1 s
// R07: after wait: clear fault, restart at start
// R08: fault-free over 4x wait: success count++
// R09: success clears consecutive failure count
// R10: success count readable, written zero clears
// R11: retry-active output on throughout retry, both polarities
// R12: overcurrent classes per selection table
// R13: overvoltage classes with selections 0,2,3,4
// R14: selections 0,4 add listed fault classes
// R15: overload and thermal relay: selection 0 only
// R16: keep only first fault of sequence
// R17: retry reset keeps accumulated thermal data
// R18: no retry of power-on storage fault
// R19: coast not 9999: use power-failure restart timing
// R20: failures count per recurring trip, cleared at reset
`timescale 1ns/1ns
module frs_fault_retry_sequencer #(
	parameter int unsigned TICK_CYCLES = frs_pkg::TICK_CYCLES
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// axi4-lite write address and data
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// fault detectors
	input wire logic [19:0] trip_event,
	input wire logic power_on_phase,
	// operator reset pin
	input wire logic manual_reset_pin,
	// run control
	output logic fault_reset_soft,
	output logic restart_start_freq,
	output logic restart_pf_timing,
	output logic excess_trip,
	output logic alarm_out,
	output logic retry_active_out,
	output logic retry_active_out_n
);
	// ----------------------------------------
	// registers and state
	// ----------------------------------------
	frs_pkg::frs_cfg_t cfg_ff;
	frs_pkg::frs_seq_t seq_ff;
	frs_pkg::frs_state_t state_ff;
	frs_pkg::frs_state_t nxt_state;
	logic [15:0] success_ff;
	logic [22:0] tick_ff;
	logic [13:0] tenth_ff;
	logic [1:0] mrst_sync_ff;
	logic aw_take;
	logic bvalid_ff;
	logic [1:0] bresp_ff;
	logic rvalid_ff;
	logic [1:0] rresp_ff;
	logic [31:0] rdata_ff;
	logic fault_reset_ff;
	logic restart_ff;
	logic [31:0] wmask;
	logic [31:0] wval;
	logic [19:0] sel_mask;
	logic [19:0] retryable;
	logic any_trip;
	logic any_retryable;
	logic [3:0] permit;
	logic retry_on;
	logic alarm_mode;
	logic tick;
	logic [11:0] wait_eff;
	logic [13:0] success_span;
	logic wait_done;
	logic success;
	logic [3:0] nxt_fail;
	logic over_limit;
	logic [4:0] first_idx;
	logic mrst;
	logic success_wr_zero;

	// ----------------------------------------
	// operator reset synchroniser
	// ----------------------------------------
	// pin is asynchronous to mclk, second stage is the only reader of the first
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			mrst_sync_ff <= 2'b00;
		end else begin
			mrst_sync_ff <= {mrst_sync_ff[0], manual_reset_pin};
		end
	end
	assign mrst = mrst_sync_ff[1];

	// ----------------------------------------
	// setting decode
	// ----------------------------------------
	// selection table per fault class; unknown selections retry nothing
	always_comb begin
		case (cfg_ff.fault_sel)
			3'h0: sel_mask = frs_pkg::MASK_SEL0; // R01 R15
			3'h1: sel_mask = frs_pkg::MASK_SEL1; // R12
			3'h2: sel_mask = frs_pkg::MASK_SEL2; // R13
			3'h3: sel_mask = frs_pkg::MASK_SEL3; // R12 R13
			3'h4: sel_mask = frs_pkg::MASK_SEL4; // R14
			3'h5: sel_mask = frs_pkg::MASK_SEL5; // R12
			default: sel_mask = '0;
		endcase
	end

	// storage fault at power-on never qualifies
	always_comb begin
		retryable = trip_event & sel_mask;
		if (power_on_phase) begin
			retryable[frs_pkg::F_PARAM_STORE] = 1'b0; // R18
		end
	end
	assign any_trip = |trip_event;
	assign any_retryable = |retryable;

	// limit decode; settings outside both bands behave as zero
	always_comb begin
		permit = 4'h0;
		alarm_mode = 1'b0;
		if (cfg_ff.count_limit != 7'h00 && cfg_ff.count_limit <= frs_pkg::LIMIT_PLAIN_MAX) begin
			permit = cfg_ff.count_limit[3:0]; // R03
		end else if (cfg_ff.count_limit >= frs_pkg::LIMIT_ALARM_MIN &&
			cfg_ff.count_limit <= frs_pkg::LIMIT_ALARM_MAX) begin
			permit = 4'(cfg_ff.count_limit - frs_pkg::LIMIT_ALARM_BASE); // R04
			alarm_mode = 1'b1; // R04
		end
	end
	assign retry_on = (permit != 4'h0); // R02

	// lowest set class names the trip
	always_comb begin
		first_idx = 5'h00;
		for (int i = frs_pkg::NFAULT - 1; i >= 0; i--) begin
			if (trip_event[i]) begin
				first_idx = 5'(i);
			end
		end
	end

	// ----------------------------------------
	// time base
	// ----------------------------------------
	// zero wait acts as one step of 0.1 s
	assign wait_eff = (cfg_ff.wait_time == 12'h000) ? frs_pkg::WAIT_FLOOR : cfg_ff.wait_time; // R06
	assign success_span = {wait_eff, 2'b00}; // R08
	assign tick = (tick_ff == 23'(TICK_CYCLES - 1));

	// prescaler restarts on every state change so each phase times from zero
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			tick_ff <= '0;
		end else if (nxt_state != state_ff || tick) begin
			tick_ff <= '0;
		end else begin
			tick_ff <= tick_ff + 23'd1;
		end
	end

	// tenths elapsed in the current phase
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			tenth_ff <= '0;
		end else if (nxt_state != state_ff) begin
			tenth_ff <= '0;
		end else if (tick && tenth_ff != 14'h3fff) begin
			tenth_ff <= tenth_ff + 14'd1;
		end
	end
	assign wait_done = (state_ff == frs_pkg::ST_WAIT) && (tenth_ff >= {2'b00, wait_eff}); // R06
	// strictly longer than four waits, with no trip in the same cycle
	assign success = (state_ff == frs_pkg::ST_CHECK) && (tenth_ff > success_span) && !any_trip; // R08

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	assign nxt_fail = seq_ff.fail_cnt + 4'd1;
	assign over_limit = (nxt_fail > permit); // R05

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			frs_pkg::ST_IDLE: begin
				if (any_retryable && retry_on) begin
					nxt_state = frs_pkg::ST_WAIT; // R01 R02
				end
			end
			frs_pkg::ST_WAIT: begin
				if (wait_done) begin
					nxt_state = frs_pkg::ST_CHECK; // R07
				end
			end
			frs_pkg::ST_CHECK: begin
				if (any_retryable && retry_on) begin
					nxt_state = over_limit ? frs_pkg::ST_EXCESS : frs_pkg::ST_WAIT; // R05
				end else if (any_trip || !retry_on) begin
					nxt_state = frs_pkg::ST_IDLE; // R01
				end else if (success) begin
					nxt_state = frs_pkg::ST_IDLE; // R08
				end
			end
			frs_pkg::ST_EXCESS: begin
				if (mrst) begin
					nxt_state = frs_pkg::ST_IDLE;
				end
			end
			default: nxt_state = frs_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= frs_pkg::ST_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// consecutive failures and the first fault of the sequence
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			seq_ff <= '{fail_cnt: frs_pkg::FAIL_RST, first_fault: 5'h00, first_vld: 1'b0}; // R20
		end else begin
			if (state_ff == frs_pkg::ST_IDLE && nxt_state == frs_pkg::ST_WAIT) begin
				seq_ff.first_fault <= first_idx; // R16
				seq_ff.first_vld <= 1'b1;
			end
			if (state_ff == frs_pkg::ST_CHECK && any_retryable && retry_on) begin
				seq_ff.fail_cnt <= nxt_fail; // R20
			end else if (success) begin
				seq_ff.fail_cnt <= frs_pkg::FAIL_RST; // R09
			end else if (state_ff == frs_pkg::ST_EXCESS && mrst) begin
				seq_ff.fail_cnt <= frs_pkg::FAIL_RST;
			end
		end
	end

	// one-cycle restart orders at the end of the wait
	// the soft reset is distinct from power-on so accumulated thermal data stay
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			fault_reset_ff <= 1'b0;
			restart_ff <= 1'b0;
		end else begin
			fault_reset_ff <= wait_done; // R07 R17
			restart_ff <= wait_done; // R07
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign fault_reset_soft = fault_reset_ff;
	assign restart_start_freq = restart_ff;
	assign restart_pf_timing = (cfg_ff.coast_time != frs_pkg::COAST_OFF); // R19
	assign excess_trip = (state_ff == frs_pkg::ST_EXCESS); // R05
	// alarm held off during retry unless the alarm band was chosen
	assign alarm_out = excess_trip ||
		(alarm_mode && (state_ff == frs_pkg::ST_WAIT || state_ff == frs_pkg::ST_CHECK)); // R03 R04
	assign retry_active_out = (state_ff == frs_pkg::ST_WAIT || state_ff == frs_pkg::ST_CHECK); // R11
	assign retry_active_out_n = !retry_active_out; // R11

	// ----------------------------------------
	// register write path
	// ----------------------------------------
	// both channels taken together, only while no response is pending
	assign aw_take = s_axi_awvalid && s_axi_wvalid && !bvalid_ff;
	assign s_axi_awready = aw_take;
	assign s_axi_wready = aw_take;
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;

	// byte strobes merge into the stored word
	always_comb begin
		wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}}, {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
		wval = '0;
		case (s_axi_awaddr)
			frs_pkg::ADDR_FAULT_SEL: wval = {29'h0, cfg_ff.fault_sel};
			frs_pkg::ADDR_COUNT_LIMIT: wval = {25'h0, cfg_ff.count_limit};
			frs_pkg::ADDR_WAIT_TIME: wval = {20'h0, cfg_ff.wait_time};
			frs_pkg::ADDR_COAST_TIME: wval = {18'h0, cfg_ff.coast_time};
			frs_pkg::ADDR_SUCCESS_COUNT: wval = {16'h0, success_ff};
			default: wval = '0;
		endcase
		wval = (wval & ~wmask) | (s_axi_wdata & wmask);
	end

	// configuration; out-of-range selection and wait are clamped on write
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_ff <= '{fault_sel: frs_pkg::SEL_RST, count_limit: frs_pkg::LIMIT_RST,
				wait_time: frs_pkg::WAIT_RST, coast_time: frs_pkg::COAST_RST}; // R06
		end else if (aw_take) begin
			case (s_axi_awaddr)
				frs_pkg::ADDR_FAULT_SEL: begin
					cfg_ff.fault_sel <= (wval[2:0] > frs_pkg::SEL_MAX) ? frs_pkg::SEL_MAX : wval[2:0];
				end
				frs_pkg::ADDR_COUNT_LIMIT: cfg_ff.count_limit <= wval[6:0];
				frs_pkg::ADDR_WAIT_TIME: begin
					cfg_ff.wait_time <= (wval[11:0] > frs_pkg::WAIT_MAX) ? frs_pkg::WAIT_MAX : wval[11:0]; // R06
				end
				frs_pkg::ADDR_COAST_TIME: cfg_ff.coast_time <= wval[13:0];
				default: cfg_ff <= cfg_ff;
			endcase
		end
	end

	// success count: a written zero clears, an increment in the same cycle leaves one
	assign success_wr_zero = aw_take && (s_axi_awaddr == frs_pkg::ADDR_SUCCESS_COUNT) &&
		(wval[15:0] == 16'h0000);
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			success_ff <= frs_pkg::SUCCESS_RST;
		end else if (success) begin
			success_ff <= success_wr_zero ? 16'h0001 : success_ff + 16'd1; // R08 R10
		end else if (success_wr_zero) begin
			success_ff <= frs_pkg::SUCCESS_RST; // R10
		end
	end

	// write response; unmapped addresses answer slave error
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			bvalid_ff <= 1'b0;
			bresp_ff <= frs_pkg::RESP_OKAY;
		end else if (aw_take) begin
			bvalid_ff <= 1'b1;
			case (s_axi_awaddr)
				frs_pkg::ADDR_FAULT_SEL, frs_pkg::ADDR_COUNT_LIMIT, frs_pkg::ADDR_WAIT_TIME,
				frs_pkg::ADDR_SUCCESS_COUNT, frs_pkg::ADDR_COAST_TIME,
				frs_pkg::ADDR_STATUS: bresp_ff <= frs_pkg::RESP_OKAY;
				default: bresp_ff <= frs_pkg::RESP_SLVERR;
			endcase
		end else if (s_axi_bready) begin
			bvalid_ff <= 1'b0;
		end
	end

	// ----------------------------------------
	// register read path
	// ----------------------------------------
	assign s_axi_arready = !rvalid_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rvalid_ff <= 1'b0;
			rresp_ff <= frs_pkg::RESP_OKAY;
			rdata_ff <= '0;
		end else if (s_axi_arvalid && !rvalid_ff) begin
			rvalid_ff <= 1'b1;
			rresp_ff <= frs_pkg::RESP_OKAY;
			rdata_ff <= '0;
			case (s_axi_araddr)
				frs_pkg::ADDR_FAULT_SEL: rdata_ff <= {29'h0, cfg_ff.fault_sel};
				frs_pkg::ADDR_COUNT_LIMIT: rdata_ff <= {25'h0, cfg_ff.count_limit};
				frs_pkg::ADDR_WAIT_TIME: rdata_ff <= {20'h0, cfg_ff.wait_time};
				frs_pkg::ADDR_SUCCESS_COUNT: rdata_ff <= {16'h0, success_ff}; // R10
				frs_pkg::ADDR_COAST_TIME: rdata_ff <= {18'h0, cfg_ff.coast_time};
				frs_pkg::ADDR_STATUS: begin
					rdata_ff[frs_pkg::ST_FAIL_LSB +: 4] <= seq_ff.fail_cnt;
					rdata_ff[frs_pkg::ST_ACTIVE] <= retry_active_out;
					rdata_ff[frs_pkg::ST_EXCESS_BIT] <= excess_trip;
					rdata_ff[frs_pkg::ST_ALARM] <= alarm_out;
					rdata_ff[frs_pkg::ST_FIRST_LSB +: 5] <= seq_ff.first_fault; // R16
					rdata_ff[frs_pkg::ST_FIRST_VLD] <= seq_ff.first_vld;
				end
				default: rresp_ff <= frs_pkg::RESP_SLVERR;
			endcase
		end else if (s_axi_rready) begin
			rvalid_ff <= 1'b0;
		end
	end
endmodule : frs_fault_retry_sequencer

// ---- hdl/frs_pkg.sv ----
// frs_pkg: constants, register map and carrier types of the fault retry sequencer.
// assumes a 20 MHz system clock and 32-bit AXI4-Lite register access.
package frs_pkg;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int unsigned CLK_HZ = 20_000_000;
	localparam int unsigned WAIT_STEP_MS = 100; // wait time resolution and zero-setting floor
	localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * WAIT_STEP_MS;
	localparam int unsigned SUCCESS_MULT_SHIFT = 2; // success needs four times the wait
	// ----------------------------------------
	// register byte offsets
	// ----------------------------------------
	localparam logic [7:0] ADDR_FAULT_SEL = 8'h00;
	localparam logic [7:0] ADDR_COUNT_LIMIT = 8'h04;
	localparam logic [7:0] ADDR_WAIT_TIME = 8'h08;
	localparam logic [7:0] ADDR_SUCCESS_COUNT = 8'h0c;
	localparam logic [7:0] ADDR_COAST_TIME = 8'h10;
	localparam logic [7:0] ADDR_STATUS = 8'h14;
	// ----------------------------------------
	// reset values and limits
	// ----------------------------------------
	localparam logic [2:0] SEL_RST = 3'h0;
	localparam logic [2:0] SEL_MAX = 3'h5;
	localparam logic [6:0] LIMIT_RST = 7'h00;
	localparam logic [6:0] LIMIT_PLAIN_MAX = 7'h0a;
	localparam logic [6:0] LIMIT_ALARM_BASE = 7'h64;
	localparam logic [6:0] LIMIT_ALARM_MIN = 7'h65;
	localparam logic [6:0] LIMIT_ALARM_MAX = 7'h6e;
	localparam logic [11:0] WAIT_RST = 12'h00a; // tenths of a second: 1 s
	localparam logic [11:0] WAIT_MAX = 12'he10; // 360 s
	localparam logic [11:0] WAIT_FLOOR = 12'h001; // zero acts as 0.1 s
	localparam logic [13:0] COAST_RST = 14'h270f;
	localparam logic [13:0] COAST_OFF = 14'h270f; // 9999: power-failure restart disabled
	localparam logic [15:0] SUCCESS_RST = 16'h0000;
	localparam logic [3:0] FAIL_RST = 4'h0;
	// ----------------------------------------
	// status field positions
	// ----------------------------------------
	localparam int unsigned ST_FAIL_LSB = 0;
	localparam int unsigned ST_ACTIVE = 4;
	localparam int unsigned ST_EXCESS_BIT = 5;
	localparam int unsigned ST_ALARM = 6;
	localparam int unsigned ST_FIRST_LSB = 8;
	localparam int unsigned ST_FIRST_VLD = 13;
	// ----------------------------------------
	// fault classes, one bit each
	// ----------------------------------------
	localparam int unsigned NFAULT = 20;
	localparam int unsigned F_PARAM_STORE = 14;
	localparam logic [19:0] MASK_SEL0 = 20'hf_ffff;
	localparam logic [19:0] MASK_SEL1 = 20'h0_0007;
	localparam logic [19:0] MASK_SEL2 = 20'h0_0038;
	localparam logic [19:0] MASK_SEL3 = 20'h0_003f;
	localparam logic [19:0] MASK_SEL4 = 20'hf_f73f;
	localparam logic [19:0] MASK_SEL5 = 20'h0_0005;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ----------------------------------------
	// carrier types
	// ----------------------------------------
	typedef struct packed {
		logic [2:0] fault_sel;
		logic [6:0] count_limit;
		logic [11:0] wait_time;
		logic [13:0] coast_time;
	} frs_cfg_t;
	typedef struct packed {
		logic [3:0] fail_cnt;
		logic [4:0] first_fault;
		logic first_vld;
	} frs_seq_t;
	typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_CHECK, ST_EXCESS} frs_state_t;
endpackage : frs_pkg

// ---- verif/frs_drive_model.sv ----
// frs_drive_model: fault detectors and run control around the sequencer.
// assumes the bench calls fire and may ask for a trip again after each restart.
`timescale 1ns/1ns
module frs_drive_model (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// run control from the sequencer
	input wire logic fault_reset_soft,
	input wire logic restart_start_freq,
	// behaviour knobs
	input wire logic refault_en,
	input wire logic [4:0] refault_idx,
	// trips and observation
	output logic [19:0] trip_event,
	output logic [7:0] restart_cnt
);
	logic [19:0] pend_vec = 20'h0_0000;
	logic [2:0] delay_ff;
	// request set off the sampling edge, so the clocked process never races it
	task automatic fire(input logic [4:0] idx);
		@(negedge mclk);
		pend_vec = 20'h0_0001 << idx;
		@(posedge mclk);
	endtask : fire
	// one-cycle trips; a faulty drive trips again three cycles after a restart
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			trip_event <= 20'h0_0000;
			delay_ff <= 3'h0;
			restart_cnt <= 8'h00;
		end else begin
			trip_event <= pend_vec | ((delay_ff == 3'h1) ? 20'h0_0001 << refault_idx : 20'h0_0000);
			pend_vec = 20'h0_0000;
			if (restart_start_freq && refault_en) begin
				delay_ff <= 3'h3;
			end else if (delay_ff != 3'h0) begin
				delay_ff <= delay_ff - 3'h1;
			end
			if (fault_reset_soft && restart_start_freq) begin
				restart_cnt <= restart_cnt + 8'h01;
			end
		end
	end
endmodule : frs_drive_model

// ---- verif/frs_fault_retry_sequencer_checker.sv ----
// frs_fault_retry_sequencer_checker: port-level assertions for the retry sequencer.
// assumes it sees the sequencer ports only, through the bind at the foot.
`timescale 1ns/1ns
module frs_fault_retry_sequencer_checker #(
	parameter int unsigned TICK_CYCLES = frs_pkg::TICK_CYCLES
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// bus handshakes
	input wire logic s_axi_awvalid,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	// sequencer
	input wire logic [19:0] trip_event,
	input wire logic fault_reset_soft,
	input wire logic restart_start_freq,
	input wire logic excess_trip,
	input wire logic alarm_out,
	input wire logic retry_active_out,
	input wire logic retry_active_out_n
);
	// ------
	// properties
	// ------
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	a_write_answer: assert property (s_axi_awvalid && s_axi_wvalid && s_axi_awready |=> s_axi_bvalid)
		else $error("write not answered next cycle");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered next cycle");
	a_active_polar: assert property (retry_active_out != retry_active_out_n)
		else $error("retry active outputs not inverse");
	a_restart_paired: assert property (fault_reset_soft == restart_start_freq)
		else $error("soft reset and restart not together");
	a_restart_single: assert property (fault_reset_soft |=> !fault_reset_soft)
		else $error("restart pulse longer than one cycle");
	a_retry_from_trip: assert property ($rose(retry_active_out) |-> $past(trip_event) != 20'h0_0000)
		else $error("retry started without a trip");
	a_wait_floor: assert property ($rose(retry_active_out) |-> !fault_reset_soft [*8])
		else $error("restart before the minimum wait");
	a_excess_quiet: assert property (excess_trip |-> !retry_active_out && !fault_reset_soft && alarm_out)
		else $error("retry activity during excess trip");
	a_excess_cause: assert property ($rose(excess_trip) |-> $past(trip_event) != 20'h0_0000)
		else $error("excess trip without a failing trip");
	a_alarm_scope: assert property (alarm_out |-> retry_active_out || excess_trip)
		else $error("alarm outside retry or excess");
	a_restart_in_retry: assert property (fault_reset_soft |-> retry_active_out)
		else $error("restart while retry inactive");
endmodule : frs_fault_retry_sequencer_checker

bind frs_fault_retry_sequencer frs_fault_retry_sequencer_checker #(.TICK_CYCLES(TICK_CYCLES))
	u_frs_fault_retry_sequencer_checker (.mclk, .rst_n, .s_axi_awvalid, .s_axi_wvalid,
	.s_axi_awready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .trip_event,
	.fault_reset_soft, .restart_start_freq, .excess_trip, .alarm_out, .retry_active_out,
	.retry_active_out_n);

// ---- verif/test_fault_retry_sequencer.sv ----
// test_fault_retry_sequencer: self-checking bench for the retry sequencer.
// assumes the drive model supplies trips and the tick is shrunk to 10 cycles.
`timescale 1ns/1ns
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_count++; \
	$display("unexpected at %0t: got %h exp %h", $time, g, e); end end
module test_fault_retry_sequencer;
	localparam int unsigned TICKS = 10;
	logic mclk, rst_n, power_on_phase, manual_reset_pin, refault_en;
	logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic fault_reset_soft, restart_start_freq, restart_pf_timing, excess_trip, alarm_out;
	logic retry_active_out, retry_active_out_n;
	logic [7:0] s_axi_awaddr, s_axi_araddr, restart_cnt;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic [19:0] trip_event;
	logic [4:0] refault_idx;
	int err_count = 0, n_compared = 0, cyc = 0, nsucc = 0;
	logic [19:0] sel_mask [6] = '{20'hf_ffff, 20'h0_0007, 20'h0_0038, 20'h0_003f, 20'hf_f73f,
		20'h0_0005};
	logic [31:0] rst_tab [7] = '{32'h0, 32'h0, 32'h0000_000a, 32'h0, 32'h0000_270f, 32'h0, 32'h0};
	// ------
	// design and drive model
	// ------
	frs_fault_retry_sequencer #(.TICK_CYCLES(TICKS)) u_frs_fault_retry_sequencer (.mclk, .rst_n,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .trip_event,
		.power_on_phase, .manual_reset_pin, .fault_reset_soft, .restart_start_freq,
		.restart_pf_timing, .excess_trip, .alarm_out, .retry_active_out, .retry_active_out_n);
	frs_drive_model u_frs_drive_model (.mclk, .rst_n, .fault_reset_soft, .restart_start_freq,
		.refault_en, .refault_idx, .trip_event, .restart_cnt);
	// ------
	// clock, timeout and bus tasks
	// ------
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	// the full run needs about 4000 cycles, so this ceiling only cuts a hang
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 40000) begin
			err_count++;
			tally_and_finish();
		end
	end
	// ready and answers are sampled at the rising edge that takes them, then released
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do @(posedge mclk); while (s_axi_awready !== 1'b1);
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		do @(posedge mclk); while (s_axi_bvalid !== 1'b1);
		rsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : wr
	// read one word into rd and rsp
	task automatic rdreg(input logic [7:0] a);
		@(posedge mclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge mclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge mclk); while (s_axi_rvalid !== 1'b1);
		rd = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rdreg
	// cycles until the restart pulse, bounded
	task automatic wait_restart(output int n);
		n = 0;
		do begin
			@(negedge mclk);
			n++;
		end while (fault_reset_soft !== 1'b1 && n < 2000);
	endtask : wait_restart
	// wait until the retry has ended, bounded
	task automatic wait_idle;
		for (int i = 0; i < 2000 && retry_active_out !== 1'b0; i++) @(negedge mclk);
	endtask : wait_idle
	// counts, then the verdict
	task automatic tally_and_finish;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : tally_and_finish
	// ------
	// test sequence
	// ------
	initial begin
		int n, base, ex;
		rst_n = 1'b0;
		power_on_phase = 1'b0;
		manual_reset_pin = 1'b0;
		refault_en = 1'b0;
		refault_idx = 5'h00;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hf;
		s_axi_awvalid = 1'b0;
		s_axi_wvalid = 1'b0;
		s_axi_bready = 1'b0;
		s_axi_arvalid = 1'b0;
		s_axi_rready = 1'b0;
		repeat (3) @(posedge mclk);
		rst_n <= 1'b1;
		for (int i = 0; i < 7; i++) begin
			rdreg(8'(i * 4));
			`CHK({rsp, rd}, {(i == 6) ? 2'h2 : 2'h0, rst_tab[i]})
		end
		u_frs_drive_model.fire(5'h00);
		repeat (3) @(negedge mclk);
		`CHK(retry_active_out, 1'b0)
		wr(frs_pkg::ADDR_COUNT_LIMIT, 32'h1);
		wr(frs_pkg::ADDR_WAIT_TIME, 32'h0);
		for (int s = 0; s < 6; s++) begin
			wr(frs_pkg::ADDR_FAULT_SEL, 32'(s));
			for (int f = 0; f < 20; f++) begin
				u_frs_drive_model.fire(5'(f));
				repeat (2) @(negedge mclk);
				`CHK(retry_active_out, sel_mask[s][f])
				`CHK(retry_active_out_n, ~sel_mask[s][f])
				`CHK(alarm_out, 1'b0)
				nsucc += int'(sel_mask[s][f]);
				wait_idle();
			end
		end
		rdreg(frs_pkg::ADDR_SUCCESS_COUNT);
		`CHK(rd, 32'(nsucc))
		wr(frs_pkg::ADDR_FAULT_SEL, 32'h0);
		@(posedge mclk);
		power_on_phase <= 1'b1;
		u_frs_drive_model.fire(5'h0e);
		repeat (2) @(negedge mclk);
		`CHK(retry_active_out, 1'b0)
		@(posedge mclk);
		power_on_phase <= 1'b0;
		wr(frs_pkg::ADDR_SUCCESS_COUNT, 32'h5);
		wr(8'h18, 32'h0);
		`CHK(rsp, frs_pkg::RESP_SLVERR)
		rdreg(frs_pkg::ADDR_SUCCESS_COUNT);
		`CHK(rd, 32'(nsucc))
		wr(frs_pkg::ADDR_SUCCESS_COUNT, 32'h0);
		`CHK(rsp, frs_pkg::RESP_OKAY)
		rdreg(frs_pkg::ADDR_SUCCESS_COUNT);
		`CHK(rd, 32'h0)
		wr(frs_pkg::ADDR_COUNT_LIMIT, 32'd101);
		for (int w = 0; w < 3; w++) begin
			wr(frs_pkg::ADDR_WAIT_TIME, 32'(w));
			u_frs_drive_model.fire(5'h00);
			wait_restart(n);
			ex = ((w == 0) ? 1 : w) * TICKS;
			`CHK((n >= ex) && (n <= ex + 3), 1'b1)
			`CHK(restart_start_freq, 1'b1)
			`CHK(alarm_out, 1'b1)
			wait_idle();
		end
		wr(frs_pkg::ADDR_COUNT_LIMIT, 32'h2);
		wr(frs_pkg::ADDR_WAIT_TIME, 32'h0);
		base = restart_cnt;
		@(posedge mclk);
		refault_en <= 1'b1;
		u_frs_drive_model.fire(5'h03);
		for (int i = 0; i < 500 && excess_trip !== 1'b1; i++) @(negedge mclk);
		`CHK(excess_trip, 1'b1)
		`CHK(8'(restart_cnt - base), 8'h03)
		rdreg(frs_pkg::ADDR_STATUS);
		`CHK(rd, 32'h0000_2363)
		@(posedge mclk);
		refault_en <= 1'b0;
		manual_reset_pin <= 1'b1;
		repeat (5) @(posedge mclk);
		manual_reset_pin <= 1'b0;
		@(negedge mclk);
		`CHK(excess_trip, 1'b0)
		@(posedge mclk);
		refault_en <= 1'b1;
		u_frs_drive_model.fire(5'h03);
		wait_restart(n);
		repeat (6) @(posedge mclk);
		refault_en <= 1'b0;
		rdreg(frs_pkg::ADDR_STATUS);
		`CHK(rd[3:0], 4'h1)
		wait_idle();
		rdreg(frs_pkg::ADDR_STATUS);
		`CHK(rd[3:0], 4'h0)
		wr(frs_pkg::ADDR_COAST_TIME, 32'd100);
		`CHK(restart_pf_timing, 1'b1)
		wr(frs_pkg::ADDR_COAST_TIME, 32'h0000_270f);
		`CHK(restart_pf_timing, 1'b0)
		tally_and_finish();
	end
endmodule : test_fault_retry_sequencer
